// [rtl/gpm_pkg.sv]
// Purpose: Shared constants and types of the gauge power-mode controller
// Assumes: 40 MHz reference clock, one-second internal time base
// Notes: All long timings count whole seconds of the time base
package gpm_pkg;

  // Reference clock and derived time base
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned T_SEC_S = 1;
  localparam int unsigned CYC_PER_SEC_DEF = CLK_HZ * T_SEC_S;

  // Mode timings in their own units
  localparam int unsigned T_LOW_QUAL_S = 16;
  localparam int unsigned T_WAKE_H = 4;
  localparam int unsigned T_CHECK_MIN = 15;

  // Timer widths
  localparam int SEC_W = 14;
  localparam int WIN_W = 10;

  // Timings as counts of time-base seconds
  localparam logic [SEC_W-1:0] LOW_QUAL_SEC = SEC_W'(T_LOW_QUAL_S);
  localparam logic [SEC_W-1:0] WAKE_SEC = SEC_W'(T_WAKE_H * 3600);
  localparam logic [WIN_W-1:0] ACT_WIN_SEC = WIN_W'(T_CHECK_MIN * 60);

  // Wake-ups per extended activity check (every third one)
  localparam logic [1:0] WAKES_PER_CHECK = 2'h3;

  // Activity limit used when the programmed threshold is zero
  localparam logic [7:0] ZERO_THR_COUNTS = 8'h02;

  // Ship-arm command: data to register address
  localparam logic [6:0] SHIP_CMD_ADDR = 7'h00;
  localparam logic [7:0] SHIP_CMD_DATA = 8'hA9;

  // Reset values
  localparam logic [7:0] ACT_CNT_RST = 8'h00;

  // Power modes as seen on the mode output
  typedef enum logic [2:0] {
    GPM_ACTIVE = 3'b000,
    GPM_SLEEP  = 3'b001,
    GPM_WAKE   = 3'b010,
    GPM_CHECK  = 3'b011,
    GPM_SHIP   = 3'b100,
    GPM_HIBER  = 3'b101
  } gpm_state_t;

  // Whole state of the controller
  typedef struct packed {
    gpm_state_t st;
    logic [1:0] line_s;
    logic [1:0] sup_s;
    logic [1:0] bak_s;
    logic [SEC_W-1:0] sec_cnt;
    logic [WIN_W-1:0] win_cnt;
    logic [7:0] act_cnt;
    logic quiet;
    logic armed;
    logic [1:0] wake_idx;
    logic temp_cap;
    logic temp_conv;
  } gpm_ctl_t;

  // Whole state of the time base
  typedef struct packed {
    logic [25:0] cnt;
    logic tick;
  } gpm_tb_t;

endpackage

// [rtl/gpm_tick_if.sv]
// Purpose: Carries the one-second tick from time base to controller
// Assumes: Single clock domain
// Notes: Tick is a one-cycle pulse
`timescale 1ns/1ps
interface gpm_tick_if;
  logic sec_tick;
  modport src(output sec_tick);
  modport snk(input sec_tick);
endinterface

// [rtl/gpm_timebase.sv]
// Purpose: Internal time base producing a one-second tick
// Assumes: CYC_PER_SEC fits in 26 bits
// Notes: Shorten CYC_PER_SEC in simulation
`timescale 1ns/1ps
module gpm_timebase
  import gpm_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = CYC_PER_SEC_DEF
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  gpm_tick_if.src tb
);

  localparam logic [25:0] LAST = 26'(CYC_PER_SEC - 1);

  gpm_tb_t r;
  gpm_tb_t n;

  // Free-running divider; no crystal, so this is the only time source
  always_comb
  begin
    n = r;
    n.tick = 1'b0;
    if (r.cnt == LAST)
    begin
      n.cnt = 26'h0;
      n.tick = 1'b1; // RULE_18
    end
    else
    begin
      n.cnt = r.cnt + 26'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= n;
  end

  assign tb.sec_tick = r.tick;

  // Tick never repeats in the cycle right after a tick
  chk_tick_spacing: assert property ( // RULE_18
    @(posedge ref_clk) disable iff (sys_rst) r.tick |=> !r.tick)
    else $error("time base tick repeated too soon");

endmodule

// [rtl/gpm_ctrl.sv]
// Purpose: Power-mode controller of a single-cell battery gauge
// Assumes: Command decoder presents host writes as one-cycle strobes
// Notes: Host line, supply and backup detect are pins, synchronised here
//
// Overview of operation
// (RULE_01) Full gauging in active; high host line never lets active fall asleep
// (RULE_02) Sleep only after 16 s low line and activity below threshold
// (RULE_03) No-activity qualification may take up to 30 minutes
// (RULE_04) Sleep stops gauging; self-discharge tracked at entry temperature
// (RULE_05) Sleep wakes every 4 h for temperature; back after 16 s low
// (RULE_06) First wake-up runs a 15-minute activity check before sleeping
// (RULE_07) Extended activity check repeats every third wake-up, 12 hours
// (RULE_08) High line ends sleep; re-entry needs a fresh 16 s qualification
// (RULE_09) Zero threshold: fewer than 2 counts in 15 min means quiet
// (RULE_10) Weak internal pull-down keeps a floating host line low
// (RULE_11) Ship-enable plus 0xA9 written to address 0x00 arms ship mode
// (RULE_12) Ship entered only when armed and line low for 16 s
// (RULE_13) While armed, short line transients do not hold active mode
// (RULE_14) Ship halts all; resumes on high line or supply POR cycle
// (RULE_15) Glitch out of ship gives active; no re-entry without new command
// (RULE_16) Hibernate on low supply with backup; exit on supply return
// (RULE_17) Any high on line clears the 16 s low qualification timer; while armed, only a high still present at the tick clears it
// (RULE_18) All timings, wake counter included, come from the time base
`timescale 1ns/1ps
module gpm_ctrl
  import gpm_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = CYC_PER_SEC_DEF
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic host_line_in,
  input wire logic converter_pulse,
  input wire logic [7:0] activity_filter_threshold,
  input wire logic cmd_wr_stb,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic ship_enable,
  input wire logic supply_above_por,
  input wire logic backup_supply_input,
  output logic [2:0] power_mode,
  output logic gauging_en,
  output logic selfdis_track,
  output logic temp_capture_stb,
  output logic temp_conv_stb,
  output logic ship_armed,
  output logic ram_retain,
  output logic host_line_pd_en,
  output logic host_line_oe_n
);

  gpm_ctl_t r;
  gpm_ctl_t n;
  logic sec_tick;
  logic line;
  logic sup;
  logic bak;
  logic [7:0] lim;
  logic win_end;
  logic ship_cmd;

  gpm_tick_if tick_if ();

  gpm_timebase #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_timebase (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tb(tick_if.src)
  );

  // Activity limit; a zero threshold falls back to a fixed count
  function automatic logic [7:0] act_limit(input logic [7:0] thr);
    if (thr == 8'h00)
      act_limit = ZERO_THR_COUNTS; // RULE_09
    else
      act_limit = thr;
  endfunction

  // Synchronised views; only second stages are read
  assign sec_tick = tick_if.sec_tick;
  assign line = r.line_s[1];
  assign sup = r.sup_s[1];
  assign bak = r.bak_s[1];
  assign lim = act_limit(activity_filter_threshold);
  assign win_end = sec_tick && (r.win_cnt == ACT_WIN_SEC - WIN_W'(1));
  assign ship_cmd = cmd_wr_stb && ship_enable &&
                    (cmd_addr == SHIP_CMD_ADDR) &&
                    (cmd_data == SHIP_CMD_DATA);

  // Next-state logic for the whole controller
  always_comb
  begin
    n = r;
    n.temp_cap = 1'b0;
    n.temp_conv = 1'b0;
    n.line_s = {r.line_s[0], host_line_in};
    n.sup_s = {r.sup_s[0], supply_above_por};
    n.bak_s = {r.bak_s[0], backup_supply_input};

    // Activity filter window runs only while the gauge is awake
    if (r.st == GPM_ACTIVE || r.st == GPM_WAKE || r.st == GPM_CHECK)
    begin
      if (converter_pulse && r.act_cnt != 8'hFF)
        n.act_cnt = r.act_cnt + 8'h01;
      if (converter_pulse && (r.act_cnt + 8'h01) >= lim)
        n.quiet = 1'b0; // RULE_03
      if (win_end)
      begin
        // Quiet only after a full window; worst case two windows
        n.quiet = (r.act_cnt < lim) && !converter_pulse; // RULE_03 RULE_09
        n.win_cnt = '0;
        n.act_cnt = ACT_CNT_RST;
      end
      else if (sec_tick)
        n.win_cnt = r.win_cnt + WIN_W'(1);
    end

    // Ship arming by host command
    if (ship_cmd)
      n.armed = 1'b1; // RULE_11

    if (!sup)
    begin
      if (bak)
      begin
        n.st = GPM_HIBER; // RULE_16
        n.sec_cnt = '0;
      end
      else
      begin
        // Supply collapse without backup acts as power-on reset
        n.st = GPM_ACTIVE; // RULE_14
        n.armed = 1'b0;
        n.sec_cnt = '0;
        n.wake_idx = 2'h0;
        n.quiet = 1'b0;
      end
    end
    else
    begin
      case (r.st)
        GPM_HIBER:
        begin
          // Capacity data retained; resume gauging
          n.st = GPM_ACTIVE; // RULE_16
          n.sec_cnt = '0;
        end
        GPM_ACTIVE:
        begin
          if (line)
          begin
            // Armed: only a level still high at the tick counts
            if (!r.armed)
              n.sec_cnt = '0; // RULE_17 RULE_01
            else if (sec_tick)
              n.sec_cnt = '0; // RULE_13
          end
          else if (sec_tick)
          begin
            if (r.sec_cnt >= LOW_QUAL_SEC)
            begin
              if (r.armed)
              begin
                // Arming is spent on entry; a command in this cycle wins
                n.st = GPM_SHIP; // RULE_12 RULE_15
                n.armed = ship_cmd;
                n.sec_cnt = '0;
              end
              else if (r.quiet)
              begin
                n.st = GPM_SLEEP; // RULE_02
                n.temp_cap = 1'b1; // RULE_04
                n.wake_idx = 2'h0;
                n.sec_cnt = '0;
              end
            end
            else
              n.sec_cnt = r.sec_cnt + SEC_W'(1);
          end
        end
        GPM_SLEEP:
        begin
          if (line)
          begin
            n.st = GPM_ACTIVE; // RULE_08
            n.sec_cnt = '0;
          end
          else if (sec_tick)
          begin
            if (r.sec_cnt == WAKE_SEC - SEC_W'(1))
            begin
              n.temp_conv = 1'b1; // RULE_05
              n.sec_cnt = '0;
              if (r.wake_idx == 2'h0)
              begin
                // Fresh window so the check spans a full period
                n.st = GPM_CHECK; // RULE_06 RULE_07
                n.win_cnt = '0;
                n.act_cnt = ACT_CNT_RST;
              end
              else
                n.st = GPM_WAKE;
              if (r.wake_idx == WAKES_PER_CHECK - 2'h1)
                n.wake_idx = 2'h0; // RULE_18
              else
                n.wake_idx = r.wake_idx + 2'h1;
            end
            else
              n.sec_cnt = r.sec_cnt + SEC_W'(1);
          end
        end
        GPM_WAKE:
        begin
          if (line)
          begin
            n.st = GPM_ACTIVE; // RULE_08
            n.sec_cnt = '0;
          end
          else if (sec_tick)
          begin
            if (r.sec_cnt == LOW_QUAL_SEC - SEC_W'(1))
            begin
              n.st = GPM_SLEEP; // RULE_05
              n.sec_cnt = '0;
            end
            else
              n.sec_cnt = r.sec_cnt + SEC_W'(1);
          end
        end
        GPM_CHECK:
        begin
          if (line)
          begin
            n.st = GPM_ACTIVE; // RULE_08
            n.sec_cnt = '0;
          end
          else if (win_end)
          begin
            n.sec_cnt = '0;
            if ((r.act_cnt < lim) && !converter_pulse)
              n.st = GPM_SLEEP; // RULE_06
            else
              n.st = GPM_ACTIVE;
          end
        end
        GPM_SHIP:
        begin
          // Everything halted until the line rises
          if (line)
          begin
            n.st = GPM_ACTIVE; // RULE_14 RULE_15
            n.sec_cnt = '0;
          end
        end
        default:
        begin
          n.st = GPM_ACTIVE;
          n.sec_cnt = '0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= n;
  end

  // Outputs decoded from registered state
  assign power_mode = r.st;
  assign gauging_en = (r.st == GPM_ACTIVE) || (r.st == GPM_WAKE) ||
                      (r.st == GPM_CHECK); // RULE_01
  assign selfdis_track = (r.st == GPM_SLEEP); // RULE_04
  assign temp_capture_stb = r.temp_cap;
  assign temp_conv_stb = r.temp_conv;
  assign ship_armed = r.armed;
  assign ram_retain = (r.st == GPM_HIBER); // RULE_16
  // Weak pull-down always on; line is never driven from here
  assign host_line_pd_en = 1'b1; // RULE_10
  assign host_line_oe_n = 1'b1;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  chk_active_line_high: assert property ( // RULE_01
    (r.st == GPM_ACTIVE) && line && sup |=>
      (r.st != GPM_SLEEP) && (r.st != GPM_SHIP))
    else $error("left active while host line high");

  chk_sleep_entry_qual: assert property ( // RULE_02
    (r.st == GPM_ACTIVE) ##1 (r.st == GPM_SLEEP) |->
      ($past(r.sec_cnt) >= LOW_QUAL_SEC) && $past(r.quiet) &&
      !$past(line))
    else $error("sleep entered without qualification");

  chk_sleep_temp_cap: assert property ( // RULE_04
    $rose(r.st == GPM_SLEEP) && $past(r.st == GPM_ACTIVE) |-> r.temp_cap)
    else $error("sleep entry without temperature capture");

  chk_wake_conv: assert property ( // RULE_05
    (r.st == GPM_SLEEP) ##1 ((r.st == GPM_WAKE) || (r.st == GPM_CHECK))
      |-> r.temp_conv)
    else $error("wake without temperature conversion");

  chk_first_wake_check: assert property ( // RULE_06
    (r.st == GPM_SLEEP) && sec_tick && sup && !line &&
    (r.sec_cnt == WAKE_SEC - SEC_W'(1)) && (r.wake_idx == 2'h0)
      |=> (r.st == GPM_CHECK) && (r.wake_idx == 2'h1))
    else $error("first wake skipped the activity check");

  chk_sleep_exit_line: assert property ( // RULE_08
    (r.st == GPM_SLEEP) && line && sup |=>
      (r.st == GPM_ACTIVE) && (r.sec_cnt == '0))
    else $error("sleep not left on high line");

  chk_ship_arm_cmd: assert property ( // RULE_11
    ship_cmd && sup && (r.st == GPM_ACTIVE) && line |=> r.armed)
    else $error("ship command did not arm");

  chk_ship_entry_armed: assert property ( // RULE_12
    $rose(r.st == GPM_SHIP) |->
      $past(r.armed) && ($past(r.sec_cnt) >= LOW_QUAL_SEC) &&
      (!r.armed || $past(ship_cmd)))
    else $error("ship entered without arming");

  chk_ship_exit_line: assert property ( // RULE_14
    (r.st == GPM_SHIP) && line && sup |=> (r.st == GPM_ACTIVE))
    else $error("ship not left on high line");

  chk_hiber_entry: assert property ( // RULE_16
    !sup && bak |=> (r.st == GPM_HIBER) && ram_retain)
    else $error("no hibernate on supply loss with backup");

endmodule

// [bench/gpm_host_model.sv]
// Purpose: Host processor model on the single-wire host line
// Assumes: Device never sinks the line, only adds a weak pull-down
// Notes: Register writes reach the controller already decoded
`timescale 1ns/1ps
module gpm_host_model
  import gpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic pd_en,
  input wire logic dev_oe_n,
  output logic line,
  output logic wr_stb,
  output logic [6:0] addr,
  output logic [7:0] data,
  output logic ship_en
);
  logic pull_up = 1'b1;
  logic drive_low = 1'b0;

  // Wire level: any sink wins, then pull-up, then device pull-down
  always_comb
  begin
    if (drive_low || !dev_oe_n)
      line = 1'b0;
    else if (pull_up)
      line = 1'b1;
    else
      line = !pd_en;
  end

  initial
  begin
    wr_stb = 1'b0;
    addr = 7'h00;
    data = 8'h00;
    ship_en = 1'b0;
  end

  // Pull-up present or not, host sinking or not
  task automatic set_line(input logic up, input logic low);
    @(negedge ref_clk);
    pull_up = up;
    drive_low = low;
  endtask

  // Mode bit is a level; the write strobe lasts one cycle
  task automatic write_reg(input logic en, input logic [6:0] a,
                           input logic [7:0] d);
    @(negedge ref_clk);
    ship_en = en;
    addr = a;
    data = d;
    wr_stb = 1'b1;
    @(negedge ref_clk);
    wr_stb = 1'b0;
  endtask
endmodule

// [bench/tb_gpm_ctrl.sv]
// Purpose: Self-checking bench of the power-mode controller
// Assumes: Four clocks per time-base second to keep the run short
// Notes: Second and later wake-ups are not reached within the run
`timescale 1ns/1ps
module tb_gpm_ctrl;
  import gpm_pkg::*;
  localparam int unsigned CPS = 4;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic conv = 1'b0;
  logic [7:0] thr = 8'h00;
  logic sup = 1'b1;
  logic bak = 1'b0;
  logic line, wr_stb, ship_en, gauging_en, selfdis, cap_stb, conv_stb;
  logic armed, retain, pd_en, oe_n;
  logic [6:0] addr;
  logic [7:0] data;
  logic [2:0] mode;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;

  always #12.5 ref_clk = ~ref_clk;

  // Cycle count since reset; keeps glitches in step with the time base
  always @(posedge ref_clk)
    cyc <= sys_rst ? 0 : cyc + 1;

  gpm_ctrl #(.CYC_PER_SEC(CPS)) gpm_ctrl_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .host_line_in(line), .converter_pulse(conv),
    .activity_filter_threshold(thr), .cmd_wr_stb(wr_stb),
    .cmd_addr(addr), .cmd_data(data), .ship_enable(ship_en),
    .supply_above_por(sup), .backup_supply_input(bak),
    .power_mode(mode), .gauging_en(gauging_en), .selfdis_track(selfdis),
    .temp_capture_stb(cap_stb), .temp_conv_stb(conv_stb),
    .ship_armed(armed), .ram_retain(retain), .host_line_pd_en(pd_en),
    .host_line_oe_n(oe_n));

  gpm_host_model gpm_host_model_i (.ref_clk(ref_clk), .pd_en(pd_en),
    .dev_oe_n(oe_n), .line(line), .wr_stb(wr_stb), .addr(addr),
    .data(data), .ship_en(ship_en));

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check_mode(input logic [2:0] got, input logic [2:0] exp,
                            input string msg);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s mode %0d", $time, msg, got);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp,
                           input string msg);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Bounded wait for a mode; cycles spent come back in cnt
  task automatic wait_mode(input logic [2:0] m, input int max,
                           output int cnt);
    cnt = 0;
    while (mode !== m)
    begin
      @(negedge ref_clk);
      cnt++;
      if (cnt > max)
      begin
        bad_count++;
        $display("CHECK FAILED at %0t: no mode %0d", $time, m);
        give_verdict();
      end
    end
  endtask

  // One-cycle high, placed away from the time-base tick
  task automatic glitch(input logic low_after);
    int k;
    k = 0;
    while (cyc % 4 != 2 && k < 8)
    begin
      @(negedge ref_clk);
      k++;
    end
    gpm_host_model_i.set_line(1'b1, 1'b0);
    gpm_host_model_i.set_line(low_after, low_after);
  endtask

  task automatic pulse_conv();
    @(negedge ref_clk);
    conv = 1'b1;
    @(negedge ref_clk);
    conv = 1'b0;
  endtask

  task automatic t_active_high();
    repeat (3800) @(negedge ref_clk);
    check_mode(mode, GPM_ACTIVE, "pulled-up line slept");
    check_bit(gauging_en, 1'b1, "gauging off in active");
    check_bit(oe_n, 1'b1, "device drives line");
    check_bit(pd_en, 1'b1, "no pull-down");
    $display("test active_high done");
  endtask

  task automatic t_low_qual();
    gpm_host_model_i.set_line(1'b0, 1'b0);
    repeat (40) @(negedge ref_clk);
    glitch(1'b0);
    wait_mode(GPM_SLEEP, 100, n);
    check_bit(n >= 64 && n <= 76, 1'b1, "low qualification time");
    check_bit(cap_stb, 1'b1, "no temperature capture");
    check_bit(selfdis, 1'b1, "no self-discharge tracking");
    check_bit(gauging_en, 1'b0, "gauging in sleep");
    $display("test low_qual done");
  endtask

  task automatic t_wake_check();
    wait_mode(GPM_CHECK, 57700, n);
    check_bit(n >= 57592, 1'b1, "early wake-up");
    check_bit(conv_stb, 1'b1, "no conversion on wake");
    check_bit(gauging_en, 1'b1, "no gauging in check");
    repeat (100) @(negedge ref_clk);
    // Programmed limit of three: two counts still count as quiet
    thr = 8'h03;
    pulse_conv();
    pulse_conv();
    wait_mode(GPM_SLEEP, 3700, n);
    thr = 8'h00;
    check_bit(n >= 3480, 1'b1, "activity check too short");
    $display("test wake_check done");
  endtask

  task automatic t_wake_high();
    gpm_host_model_i.set_line(1'b1, 1'b0);
    wait_mode(GPM_ACTIVE, 5, n);
    gpm_host_model_i.set_line(1'b0, 1'b0);
    wait_mode(GPM_SLEEP, 90, n);
    check_bit(n >= 64, 1'b1, "sleep re-entry too soon");
    gpm_host_model_i.set_line(1'b1, 1'b0);
    wait_mode(GPM_ACTIVE, 5, n);
    $display("test wake_high done");
  endtask

  task automatic t_ship();
    gpm_host_model_i.write_reg(1'b1, 7'h01, 8'hA9);
    gpm_host_model_i.write_reg(1'b1, 7'h00, 8'hA8);
    gpm_host_model_i.write_reg(1'b0, 7'h00, 8'hA9);
    check_bit(armed, 1'b0, "armed by wrong command");
    gpm_host_model_i.write_reg(1'b1, 7'h00, 8'hA9);
    check_bit(armed, 1'b1, "ship not armed");
    pulse_conv();
    pulse_conv();
    gpm_host_model_i.set_line(1'b1, 1'b1);
    repeat (20) @(negedge ref_clk);
    glitch(1'b1);
    wait_mode(GPM_SHIP, 120, n);
    check_bit(n <= 56, 1'b1, "transient held active");
    check_bit(gauging_en, 1'b0, "gauging in ship");
    glitch(1'b0);
    wait_mode(GPM_ACTIVE, 6, n);
    check_bit(armed, 1'b0, "arming survived ship");
    repeat (80) @(negedge ref_clk);
    check_mode(mode, GPM_ACTIVE, "slept with activity");
    // Window holding the counts ends first; quiet needs the next one
    wait_mode(GPM_SLEEP, 7300, n);
    gpm_host_model_i.set_line(1'b1, 1'b0);
    gpm_host_model_i.write_reg(1'b1, 7'h00, 8'hA9);
    gpm_host_model_i.set_line(1'b0, 1'b0);
    wait_mode(GPM_SHIP, 80, n);
    @(negedge ref_clk);
    sup = 1'b0;
    wait_mode(GPM_ACTIVE, 6, n);
    // Re-arm once supply is seen again, then drop it once more
    sup = 1'b1;
    repeat (3) @(negedge ref_clk);
    gpm_host_model_i.write_reg(1'b1, 7'h00, 8'hA9);
    check_bit(armed, 1'b1, "ship not re-armed");
    sup = 1'b0;
    repeat (4) @(negedge ref_clk);
    check_bit(armed, 1'b0, "arming survived power loss");
    sup = 1'b1;
    $display("test ship done");
  endtask

  task automatic t_hiber();
    gpm_host_model_i.set_line(1'b1, 1'b0);
    bak = 1'b1;
    @(negedge ref_clk);
    sup = 1'b0;
    wait_mode(GPM_HIBER, 6, n);
    check_bit(retain, 1'b1, "no retention");
    check_bit(gauging_en, 1'b0, "gauging in hibernate");
    @(negedge ref_clk);
    sup = 1'b1;
    wait_mode(GPM_ACTIVE, 6, n);
    check_bit(retain, 1'b0, "retention after exit");
    $display("test hiber done");
  endtask

  initial
  begin
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_active_high();
    t_low_qual();
    t_wake_check();
    t_wake_high();
    t_ship();
    t_hiber();
    give_verdict();
  end
endmodule
